// ===== core/adcsc_ctrl.sv
// Purpose: Serial control and conversion sequencing of an 8-channel 12-bit SAR converter
// Assumes: comp_in is the comparator output for the driven DAC code, settled within a clock
// Notes: Link logic runs on sclk_in; internal clock conversions run on clk_in
`timescale 1ns/1ps
`include "adcsc_cfg.svh"

// Overview of operation
// - Serial input is shifted in on rising serial clock edges up to the eighth control bit.
// - Serial input is ignored while chip select is high.
// - Serial output changes only on falling serial clock edges.
// - Serial output is released whenever chip select is high.
// - Internal clock mode: strobe low at conversion start, high when done.
// - External clock mode: strobe high one serial period before MSB decision.
// - External clock mode: strobe released while chip select is high.
// - External clock mode: serial clock paces the conversion steps.
// - Shutdown pin low powers the device down.
// - Tracking begins on the falling edge after the fifth control bit.
// - Hold begins on the falling edge after the eighth control bit.
// - Conversion starts by switching the hold capacitor to the negative input.
// - After conversion the hold capacitor returns to the positive input.
// - Each sample is resolved by successive approximation into 12 bits.
// - Single-ended: any of eight inputs positive, negative is analog ground.
// - Differential: inputs taken from adjacent pairs zero/one up to six/seven.
// - Leading zeros are discarded; the first one is the start bit.
// - Control byte: start, three channel bits, polarity, config, two mode bits.
// - Both mode bits one selects external clock mode without power-down.
// - An external clock conversion cycle takes fifteen serial clocks.
module adcsc_ctrl (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic sclk_in,
  input wire logic cs_n_in,
  input wire logic din_in,
  input wire logic power_off_pin_n_in,
  input wire logic comp_in,
  output logic dout_out,
  output logic dout_oe_out,
  output logic conversion_strobe_out,
  output logic strobe_oe_out,
  output logic track_out,
  output logic hold_on_neg_out,
  output adcsc_pkg::adcsc_mux_s mux_out,
  output logic [11:0] dac_code_out,
  output logic unipolar_out,
  output logic shutdown_out,
  output logic full_pd_out,
  output logic fast_pd_out
);

  ////////////////////////////////////////////////////////////////////////////////
  // Functions

  function automatic adcsc_pkg::adcsc_ctrl_s ctrl_of(input logic [7:0] b);
    adcsc_pkg::adcsc_ctrl_s c;
    c.start = b[`ADCSC_POS_START];
    c.chan_sel_hi = b[`ADCSC_POS_SEL_HI];
    c.chan_sel_mid = b[`ADCSC_POS_SEL_MID];
    c.chan_sel_lo = b[`ADCSC_POS_SEL_LO];
    c.polarity_select = b[`ADCSC_POS_POLARITY];
    c.input_config_select = b[`ADCSC_POS_CONFIG];
    c.pwr_mode_hi = b[`ADCSC_POS_PWR_HI];
    c.pwr_mode_lo = b[`ADCSC_POS_PWR_LO];
    return c;
  endfunction

  function automatic adcsc_pkg::adcsc_mux_s mux_of(input adcsc_pkg::adcsc_ctrl_s c);
    adcsc_pkg::adcsc_mux_s m;
    m.pos = {c.chan_sel_mid, c.chan_sel_lo, c.chan_sel_hi};
    m.neg_is_analog_ground = c.input_config_select;
    m.neg = m.pos ^ 3'h1;
    return m;
  endfunction

  function automatic logic [11:0] sar_step(input logic [11:0] code, input logic [3:0] idx,
                                           input logic keep);
    logic [11:0] d;
    d = code;
    d[idx] = keep;
    if (idx != 4'h0) begin
      d[idx - 4'h1] = 1'b1;
    end
    return d;
  endfunction

  function automatic logic is_ext(input logic [7:0] b);
    return {b[`ADCSC_POS_PWR_HI], b[`ADCSC_POS_PWR_LO]} == `ADCSC_MODE_EXT;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // State

  adcsc_pkg::adcsc_rise_s r;
  adcsc_pkg::adcsc_rise_s next_r;
  adcsc_pkg::adcsc_fall_s f;
  adcsc_pkg::adcsc_fall_s next_f;
  adcsc_pkg::adcsc_keep_s k;
  adcsc_pkg::adcsc_keep_s next_k;
  adcsc_pkg::adcsc_clk_s c;
  adcsc_pkg::adcsc_clk_s next_c;
  logic link_rst;
  logic [1:0] mode_int;

  assign link_rst = rst_in | cs_n_in;
  assign mode_int = {k.ctrl[`ADCSC_POS_PWR_HI], k.ctrl[`ADCSC_POS_PWR_LO]};

  ////////////////////////////////////////////////////////////////////////////////
  // Rising edge: control byte capture

  always_comb begin
    next_r = r;
    next_r.pd_meta = power_off_pin_n_in;
    next_r.pd_sync = r.pd_meta;
    if (r.cnt == 4'h0 || r.cnt == `ADCSC_FRAME_CLKS) begin
      if (din_in && r.pd_sync) begin
        next_r.sh = `ADCSC_SHIFT_START;
        next_r.cnt = 4'h1;
      end else begin
        next_r.cnt = 4'h0;
      end
    end else begin
      if (r.cnt < `ADCSC_HOLD_AT) begin
        next_r.sh = {r.sh[6:0], din_in};
      end
      next_r.cnt = r.cnt + 4'h1;
    end
  end

  always_ff @(posedge sclk_in or posedge link_rst) begin
    if (link_rst) begin
      r <= '{cnt: 4'h0, sh: 8'h00, pd_meta: 1'b1, pd_sync: 1'b1};
    end else begin
      r <= next_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Falling edge: track/hold, external SAR, result shifting

  always_comb begin
    next_f = f;
    next_k = k;
    next_k.done_meta = c.done_tgl;
    next_k.done_sync = k.done_meta;
    next_f.dout_oe = 1'b1;
    next_f.strobe = 1'b0;
    if (r.cnt == `ADCSC_TRACK_AT) begin
      next_k.track = 1'b1;
      next_k.mux.pos = mux_of(ctrl_of({r.sh[4:0], 3'h0})).pos;
    end
    if (r.cnt == `ADCSC_HOLD_AT) begin
      next_k.track = 1'b0;
      next_k.mux = mux_of(ctrl_of(r.sh));
      next_k.ctrl = r.sh;
      next_k.mode_ext = is_ext(r.sh);
      if (is_ext(r.sh)) begin
        next_f.strobe = 1'b1;
        next_f.on_neg = 1'b1;
        next_f.conv = 1'b1;
        next_f.dac = `ADCSC_MSB_TRIAL;
        next_f.sar_cnt = `ADCSC_RES_BITS;
      end else begin
        next_k.req_tgl = ~k.req_tgl;
      end
    end
    if (f.conv) begin
      next_f.dout = comp_in;
      next_f.dac = sar_step(f.dac, f.sar_cnt - 4'h1, comp_in);
      next_f.sar_cnt = f.sar_cnt - 4'h1;
      if (f.sar_cnt == 4'h1) begin
        next_f.conv = 1'b0;
        next_f.on_neg = 1'b0;
        next_k.track = 1'b1;
      end
    end else if (f.out_cnt != 4'h0) begin
      next_f.dout = f.out_sh[11];
      next_f.out_sh = {f.out_sh[10:0], 1'b0};
      next_f.out_cnt = f.out_cnt - 4'h1;
    end else begin
      next_f.dout = 1'b0;
    end
    if (k.done_sync != k.done_seen) begin
      next_k.done_seen = k.done_sync;
      next_k.track = 1'b1;
      next_f.out_sh = c.result;
      next_f.out_cnt = `ADCSC_RES_BITS;
    end
    next_f.strobe_oe = next_k.mode_ext;
  end

  always_ff @(negedge sclk_in or posedge link_rst) begin
    if (link_rst) begin
      f <= '0;
    end else begin
      f <= next_f;
    end
  end

  always_ff @(negedge sclk_in or posedge rst_in) begin
    if (rst_in) begin
      k <= '0;
    end else begin
      k <= next_k;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Internal clock conversion and power state

  always_comb begin
    next_c = c;
    next_c.pd_meta = power_off_pin_n_in;
    next_c.pd_sync = c.pd_meta;
    next_c.shut = ~c.pd_sync;
    next_c.req_meta = k.req_tgl;
    next_c.req_sync = c.req_meta;
    if (c.req_sync != c.req_seen) begin
      next_c.req_seen = c.req_sync;
      next_c.full_pd = 1'b0;
      next_c.fast_pd = 1'b0;
      next_c.busy = 1'b1;
      next_c.strobe = 1'b0;
      next_c.on_neg = 1'b1;
      next_c.dac = `ADCSC_MSB_TRIAL;
      next_c.sar_cnt = `ADCSC_RES_BITS;
    end else if (c.busy) begin
      next_c.dac = sar_step(c.dac, c.sar_cnt - 4'h1, comp_in);
      next_c.sar_cnt = c.sar_cnt - 4'h1;
      if (c.sar_cnt == 4'h1) begin
        next_c.busy = 1'b0;
        next_c.strobe = 1'b1;
        next_c.on_neg = 1'b0;
        next_c.result = sar_step(c.dac, 4'h0, comp_in);
        next_c.done_tgl = ~c.done_tgl;
        next_c.full_pd = mode_int == `ADCSC_MODE_FULL_PD;
        next_c.fast_pd = mode_int == `ADCSC_MODE_FAST_PD;
      end
    end
    if (!c.pd_sync) begin
      next_c.busy = 1'b0;
      next_c.strobe = 1'b1;
      next_c.on_neg = 1'b0;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      c <= '{pd_meta: 1'b1, pd_sync: 1'b1, strobe: 1'b1, default: '0};
    end else begin
      c <= next_c;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign dout_out = f.dout;
  assign dout_oe_out = f.dout_oe;
  assign conversion_strobe_out = k.mode_ext ? f.strobe : c.strobe;
  assign strobe_oe_out = k.mode_ext ? f.strobe_oe : 1'b1;
  assign track_out = k.track;
  assign hold_on_neg_out = f.on_neg | c.on_neg;
  assign mux_out = k.mux;
  assign dac_code_out = k.mode_ext ? f.dac : c.dac;
  assign unipolar_out = k.ctrl[`ADCSC_POS_POLARITY];
  assign shutdown_out = c.shut;
  assign full_pd_out = c.full_pd;
  assign fast_pd_out = c.fast_pd;

endmodule

// ===== core/adcsc_cfg.svh
// Purpose: Offsets, field positions, mode codes, load values and counts of the converter control
// Assumes: Included by the design file only
// Notes: Positions are bit indices of the control byte
`ifndef ADCSC_CFG_SVH
`define ADCSC_CFG_SVH

`define ADCSC_POS_START 3'h7
`define ADCSC_POS_SEL_HI 3'h6
`define ADCSC_POS_SEL_MID 3'h5
`define ADCSC_POS_SEL_LO 3'h4
`define ADCSC_POS_POLARITY 3'h3
`define ADCSC_POS_CONFIG 3'h2
`define ADCSC_POS_PWR_HI 3'h1
`define ADCSC_POS_PWR_LO 3'h0

`define ADCSC_MODE_FULL_PD 2'h0
`define ADCSC_MODE_FAST_PD 2'h1
`define ADCSC_MODE_EXT 2'h3

`define ADCSC_TRACK_AT 4'h5
`define ADCSC_HOLD_AT 4'h8
`define ADCSC_FRAME_CLKS 4'hf
`define ADCSC_RES_BITS 4'hc
`define ADCSC_MSB_TRIAL 12'h800
`define ADCSC_SHIFT_START 8'h01

`endif

// ===== core/adcsc_pkg.sv
// Purpose: Types of the serial converter control
// Assumes: Nothing
// Notes: Field order of the control struct matches the control byte
package adcsc_pkg;

  typedef struct packed {
    logic start;
    logic chan_sel_hi;
    logic chan_sel_mid;
    logic chan_sel_lo;
    logic polarity_select;
    logic input_config_select;
    logic pwr_mode_hi;
    logic pwr_mode_lo;
  } adcsc_ctrl_s;

  typedef struct packed {
    logic [2:0] pos;
    logic neg_is_analog_ground;
    logic [2:0] neg;
  } adcsc_mux_s;

  typedef struct packed {
    logic [3:0] cnt;
    logic [7:0] sh;
    logic pd_meta;
    logic pd_sync;
  } adcsc_rise_s;

  typedef struct packed {
    logic on_neg;
    logic conv;
    logic strobe;
    logic strobe_oe;
    logic dout;
    logic dout_oe;
    logic [3:0] sar_cnt;
    logic [11:0] dac;
    logic [11:0] out_sh;
    logic [3:0] out_cnt;
  } adcsc_fall_s;

  typedef struct packed {
    logic mode_ext;
    logic track;
    adcsc_mux_s mux;
    logic [7:0] ctrl;
    logic req_tgl;
    logic done_meta;
    logic done_sync;
    logic done_seen;
  } adcsc_keep_s;

  typedef struct packed {
    logic pd_meta;
    logic pd_sync;
    logic shut;
    logic req_meta;
    logic req_sync;
    logic req_seen;
    logic busy;
    logic strobe;
    logic on_neg;
    logic [3:0] sar_cnt;
    logic [11:0] dac;
    logic [11:0] result;
    logic done_tgl;
    logic full_pd;
    logic fast_pd;
  } adcsc_clk_s;

endpackage

// ===== test/adcsc_ctrl_sva.sv
// Purpose: Port assertions of the converter control
// Assumes: Bound to adcsc_ctrl
// Notes: Two domains, clk_in and sclk_in
`timescale 1ns/1ps
module adcsc_ctrl_chk (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic sclk_in,
  input wire logic cs_n_in,
  input wire logic power_off_pin_n_in,
  input wire logic dout_out,
  input wire logic dout_oe_out,
  input wire logic conversion_strobe_out,
  input wire logic track_out,
  input wire logic hold_on_neg_out,
  input wire adcsc_pkg::adcsc_mux_s mux_out,
  input wire logic [11:0] dac_code_out,
  input wire logic shutdown_out
);
  logic d_r;
  always_ff @(posedge sclk_in) d_r <= dout_out;
  sequence s_ext;
    $rose(conversion_strobe_out) && hold_on_neg_out;
  endsequence
  sequence s_int;
    $fell(conversion_strobe_out) && $rose(hold_on_neg_out);
  endsequence
  property p_oe_off;
    @(posedge clk_in) disable iff (rst_in) cs_n_in |-> !dout_oe_out;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("dout enabled");
  property p_dout_hold;
    @(negedge sclk_in) disable iff (rst_in || cs_n_in) dout_out == d_r;
  endproperty
  a_dout_hold: assert property (p_dout_hold) else $error("dout moved");
  property p_pulse;
    @(posedge sclk_in) disable iff (rst_in || cs_n_in) s_ext |=> !conversion_strobe_out;
  endproperty
  a_pulse: assert property (p_pulse) else $error("strobe width");
  property p_ext_len;
    @(posedge sclk_in) disable iff (rst_in || cs_n_in)
      s_ext |-> ##11 hold_on_neg_out ##1 (track_out && !hold_on_neg_out);
  endproperty
  a_ext_len: assert property (p_ext_len) else $error("cycle length");
  property p_first;
    @(posedge sclk_in) disable iff (rst_in || cs_n_in) s_ext |-> dac_code_out == 12'h800;
  endproperty
  a_first: assert property (p_first) else $error("first trial");
  property p_int;
    @(posedge clk_in) disable iff (rst_in)
      s_int |-> ##12 (conversion_strobe_out && !hold_on_neg_out);
  endproperty
  a_int: assert property (p_int) else $error("internal conversion");
  property p_hold;
    @(posedge clk_in) disable iff (rst_in) $rose(hold_on_neg_out) |-> !track_out;
  endproperty
  a_hold: assert property (p_hold) else $error("hold order");
  property p_power_off_pin;
    @(posedge clk_in) disable iff (rst_in) $fell(power_off_pin_n_in) |-> ##[2:3] shutdown_out;
  endproperty
  a_power_off_pin: assert property (p_power_off_pin) else $error("shutdown late");
  property p_pair;
    @(posedge clk_in) disable iff (rst_in) hold_on_neg_out && !mux_out.neg_is_analog_ground
      |-> mux_out.neg == (mux_out.pos ^ 3'h1);
  endproperty
  a_pair: assert property (p_pair) else $error("pair");
endmodule
bind adcsc_ctrl adcsc_ctrl_chk u_chk (.*);

// ===== test/adcsc_master.sv
// Purpose: Serial master model
// Assumes: Link clock 15 ns, idle low
// Notes: Data set up while clock low
`timescale 1ns/1ps
module adcsc_master (
  input wire logic dout_in,
  input wire logic strobe_in,
  output logic sclk_out,
  output logic cs_n_out,
  output logic din_out
);
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    din_out = 1'b1;
  end
  task automatic tick(input logic b, inout logic [23:0] rx, inout logic [23:0] sb);
    din_out = b;
    #7.5 sclk_out = 1'b1;
    rx = {rx[22:0], dout_in};
    sb = {sb[22:0], strobe_in};
    #7.5 sclk_out = 1'b0;
  endtask
  task automatic xfer(input logic [7:0] cb, input int lead, input bit intm,
                      output logic [23:0] rx, output logic [23:0] sb);
    int i;
    int k;
    bit seen;
    rx = '0;
    sb = '0;
    seen = 1'b0;
    #30 cs_n_out = 1'b0;
    #20;
    for (i = 0; i < lead; i++) tick(1'b0, rx, sb);
    for (i = 0; i < 24; i++) begin
      for (k = 0; intm && i == 8 && k < 60 && !(seen && strobe_in); k++) begin
        #15;
        seen |= !strobe_in;
      end
      if (i == 5) #1500;
      tick(i < 8 ? cb[7 - i] : 1'b0, rx, sb);
    end
    din_out = ~din_out;
    #20 cs_n_out = 1'b1;
  endtask
endmodule

// ===== test/tb.sv
// Purpose: Bench of the converter control
// Assumes: Ideal comparator against vin
// Notes: Master model drives the link
`timescale 1ns/1ps
module tb;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic pwr_n = 1'b1;
  logic sclk, cs_n, din, dout, dout_oe, stb, stb_oe, track, on_neg, uni, power_off_pin, fpd, qpd;
  logic [11:0] dac;
  logic [11:0] vin = 12'h000;
  logic [23:0] rx, sb;
  adcsc_pkg::adcsc_mux_s mux;
  int n_fail = 0;
  int samples_checked = 0;
  int cyc = 0;
  bit prev_ext = 1'b0;
  adcsc_ctrl uut (.clk_in(clk_in), .rst_in(rst_in), .sclk_in(sclk), .cs_n_in(cs_n),
    .din_in(din), .power_off_pin_n_in(pwr_n), .comp_in(dac <= vin), .dout_out(dout),
    .dout_oe_out(dout_oe), .conversion_strobe_out(stb), .strobe_oe_out(stb_oe),
    .track_out(track), .hold_on_neg_out(on_neg), .mux_out(mux), .dac_code_out(dac),
    .unipolar_out(uni), .shutdown_out(power_off_pin), .full_pd_out(fpd), .fast_pd_out(qpd));
  adcsc_master m (.dout_in(dout), .strobe_in(stb), .sclk_out(sclk), .cs_n_out(cs_n),
    .din_out(din));
  initial forever #12.5 clk_in = ~clk_in;
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    $display("checked=%0d failed=%0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      test_done();
    end
  end
  task automatic ext(input logic [7:0] cb, input logic [11:0] v, input int lead);
    vin = v;
    m.xfer(cb, lead, 1'b0, rx, sb);
    #1;
    chk(rx[14:3], v);
    chk(sb, prev_ext ? 24'h008000 : 24'hff8000);
    prev_ext = 1'b1;
    chk({mux.pos, mux.neg_is_analog_ground, uni}, {cb[5], cb[4], cb[6], cb[2], cb[3]});
    if (!cb[2]) chk(mux.neg, {cb[5], cb[4], ~cb[6]});
    chk({dout_oe, stb_oe, track}, 3'b001);
  endtask
  task automatic intl(input logic [1:0] md, input logic [11:0] v);
    vin = v;
    m.xfer({6'b101111, md}, 0, 1'b1, rx, sb);
    #1;
    prev_ext = 1'b0;
    chk(rx[11:0], v);
    chk({fpd, qpd, stb_oe}, {md == 2'b00, md == 2'b01, 1'b1});
  endtask
  initial begin
    repeat (12) @(negedge clk_in);
    chk({stb, stb_oe, dout_oe}, 3'b110);
    rst_in = 1'b0;
    #3;
    for (int c = 0; c < 16; c++) begin
      ext({1'b1, c[2:0], c[0], c[3], 2'b11}, 12'hfff - 12'(c) * 12'h111, c % 3);
    end
    intl(2'b00, 12'h9c5);
    intl(2'b01, 12'h001);
    intl(2'b10, 12'hffe);
    @(negedge clk_in) pwr_n = 1'b0;
    repeat (4) @(negedge clk_in);
    chk(power_off_pin, 1'b1);
    m.xfer(8'hff, 2, 1'b0, rx, sb);
    chk(sb, 24'hffffff);
    @(negedge clk_in) pwr_n = 1'b1;
    repeat (4) @(negedge clk_in);
    chk(power_off_pin, 1'b0);
    ext(8'h8f, 12'h3c3, 1);
    test_done();
  end
endmodule
